// ---- rtl/reset_and_watchdog_control.sv ----
`timescale 1ns/1ns
`include "rst_wdt_map.svh"
// How it works
// [R01] Power-on, the pin, a software command, the watchdog and low supply all reset the chip.
// [R02] After power-on, reset holds for 40 ms, then the high config byte loads, then release.
// [R03] The active-low reset pin must stay low for two slow RC periods to be taken.
// [R04] The pin is ignored unless the pin-reset enable bit of the config byte is set.
// [R05] Writing 56h to the command port at 97h resets the chip.
// [R06] The watchdog counts edges of the slow internal RC clock, whatever the system clock.
// [R07] Watchdog enable 0x is off, 10 acts in fast and slow mode, 11 acts in every mode.
// [R08] The period field picks 480, 240, 120 or 60 ms for codes 00 to 11.
// [R09] Any reset and the watchdog clear bit zero the watchdog counter.
// [R10] The watchdog clear bit falls by itself one cycle after it is set.
// [R11] Undervolt select 00, 01, 10, 11 give 3.6, 2.8, 4.3 and 2.3 V, 11 also enables detect.
// [R12] The read-only detect flag follows the 2.8 V level, only with 11 and never in stop.
// [R13] Power save forces 2.3 V in idle and switches undervolt reset off in stop, as does 11.
// [R14] Every register returns to its default on any reset.
// [R15] A watchdog overflow resets only when the enable field allows it.
// [R16] All requests merge into one reset held while any is active, released on mclk.
// [R17] Writing 65h to the command port unlocks flash writes, any other value locks them.
module reset_and_watchdog_control #(
    parameter int WARMUP_CYCLES = `WARMUP_MS * (`MCLK_HZ / 1000)
) (
    // clock and power-on reset
    input  wire logic                     mclk,
    input  wire logic                     srst,
    // pins and analog comparators
    input  wire logic                     ext_reset_n,
    input  wire logic                     slow_internal_rc,
    input  wire rst_wdt_pkg::uv_cmp_type  uv_cmp,
    // cpu operating mode
    input  wire logic                     cpu_idle,
    input  wire logic                     cpu_stop,
    // special function register port
    input  wire rst_wdt_pkg::sfr_req_type sfr,
    output logic [7:0]                    sfr_rdata,
    // config byte fetch from program memory
    output logic                          cfg_read_req,
    input  wire logic                     cfg_read_ack,
    input  wire logic [7:0]               cfg_read_data,
    // results
    output logic                          sys_rst,
    output logic                          flash_write_unlock_flag,
    output logic                          undervolt_detect_flag
);
    import rst_wdt_pkg::*;

    state_type   q;
    state_type   d;
    logic        src_rise;
    logic        pin_req;
    logic        sw_req;
    logic        wdt_req;
    logic        undervolt_reset;
    logic        lv_off;
    logic        lv_use23;
    logic        normal_mode;
    logic        wdt_run;
    logic [1:0]  uv_sel;
    logic [1:0]  wdog_en;
    logic [15:0] wdt_limit;
    logic        sfr_wr_ok;

    // =====================================================
    // watchdog period in slow RC ticks
    function automatic logic [15:0] wdt_ticks(input logic [1:0] psc);
        int t;
        t = ((`WDT_BASE_MS >> psc) * `RC_SLOW_HZ) / 1000;
        return t[15:0];
    endfunction

    // =====================================================
    // next state
    always_comb begin
        d = q;
        // pins pass three flops; a level counts once stages two and three agree
        d.s1 = {uv_cmp.below_4v3, uv_cmp.below_3v6, uv_cmp.below_2v8,
                uv_cmp.below_2v3, slow_internal_rc, ext_reset_n};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < 6; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.filt[i] = q.s3[i];
            end
        end
        src_rise = d.filt[1] & ~q.filt[1]; // see [R06]
        normal_mode = ~cpu_idle & ~cpu_stop;
        sfr_wr_ok = sfr.wr & ~q.sys_rst;

        // external pin, qualified in slow RC periods
        if (q.filt[0]) begin
            d.pin_cnt = 2'h0;
        end else if (src_rise && q.pin_cnt != `PIN_MIN_TICKS) begin
            d.pin_cnt = q.pin_cnt + 2'h1; // see [R03]
        end
        pin_req = q.cfg_high[`PINRST_EN_BIT] & ~q.filt[0]
                  & (q.pin_cnt == `PIN_MIN_TICKS); // see [R04]

        // software command port
        sw_req = sfr_wr_ok && sfr.addr == `OFS_CMD_PORT
                 && sfr.wdata == `CMD_SOFT_RESET; // see [R05]
        if (sfr_wr_ok && sfr.addr == `OFS_CMD_PORT) begin
            d.unlock = (sfr.wdata == `CMD_UNLOCK); // see [R17]
        end

        // undervolt threshold by mode
        uv_sel = q.cfg_high[`UVSEL_LSB +: 2];
        lv_off = cpu_stop & (q.ctl_two[`POWER_SAVE_BIT] | uv_sel == 2'h3); // see [R13]
        lv_use23 = (cpu_idle & q.ctl_two[`POWER_SAVE_BIT]) | uv_sel == 2'h3; // see [R13]
        if (lv_off) begin
            undervolt_reset = 1'b0;
        end else if (lv_use23) begin
            undervolt_reset = q.filt[2];
        end else begin
            unique case (uv_sel) // see [R11]
                2'h0: undervolt_reset = q.filt[4];
                2'h1: undervolt_reset = q.filt[3];
                default: undervolt_reset = q.filt[5];
            endcase
        end
        d.detect = (uv_sel == 2'h3) & ~cpu_stop & q.filt[3]; // see [R12]

        // watchdog, counted on slow RC edges
        wdog_en = q.ctl_two[`WDOG_EN_LSB +: 2];
        wdt_limit = wdt_ticks(q.option[`WDT_PSC_LSB +: 2]); // see [R08]
        wdt_run = normal_mode | (wdog_en == 2'h3);
        wdt_req = 1'b0;
        if (q.ctl_one[`WDOG_CLR_BIT]) begin
            d.wdt = 16'h0000; // see [R09]
        end else if (src_rise && wdt_run) begin // see [R06]
            // at or past the limit: a shorter period picked mid-count overflows at once
            if (q.wdt >= wdt_limit - 16'h0001) begin
                d.wdt = 16'h0000;
                wdt_req = wdog_en[1] & (normal_mode | wdog_en[0]); // see [R07] [R15]
            end else begin
                d.wdt = q.wdt + 16'h0001;
            end
        end

        // register writes
        if (sfr_wr_ok) begin
            unique case (sfr.addr)
                `OFS_OPTION: d.option = sfr.wdata;
                `OFS_CTL_TWO: d.ctl_two = sfr.wdata;
                `OFS_CTL_ONE: d.ctl_one = sfr.wdata;
                default:      ;
            endcase
        end
        if (!(sfr_wr_ok && sfr.addr == `OFS_CTL_ONE)) begin
            d.ctl_one[`WDOG_CLR_BIT] = 1'b0; // see [R10]
        end

        // register reads; unmapped and reserved bits read zero
        if (sfr.rd) begin
            unique case (sfr.addr)
                `OFS_OPTION: d.rdata = q.option;
                `OFS_FLAG_BANK: d.rdata = {q.detect, 7'h00};
                `OFS_CMD_PORT:  d.rdata = {7'h00, q.unlock};
                `OFS_CTL_TWO:   d.rdata = q.ctl_two;
                `OFS_CTL_ONE:   d.rdata = q.ctl_one;
                default:        d.rdata = 8'h00;
            endcase
        end

        // power-on sequence
        unique case (q.phase)
            PH_WARMUP: begin
                d.warm = q.warm + 19'h00001;
                if (q.warm == 19'(WARMUP_CYCLES - 1)) begin
                    d.phase = PH_CFG_LOAD; // see [R02]
                    d.cfg_req = 1'b1;
                end
            end
            PH_CFG_LOAD: begin
                if (cfg_read_ack) begin
                    d.cfg_high = cfg_read_data; // see [R02]
                    d.cfg_req = 1'b0;
                    d.phase = PH_RUN;
                end
            end
            PH_RUN: ;
        endcase

        // merge and stretch; a short pulse still gives a clean reset
        if (pin_req | sw_req | wdt_req | undervolt_reset) begin // see [R01]
            d.hold = `HOLD_CYCLES;
        end else if (q.hold != 3'h0) begin
            d.hold = q.hold - 3'h1;
        end
        d.sys_rst = (q.phase != PH_RUN) | pin_req | sw_req | wdt_req
                    | undervolt_reset | (q.hold != 3'h0); // see [R16]

        // defaults while reset stands
        if (q.sys_rst) begin // see [R14]
            d.option = `OPTION_RST;
            d.ctl_two = `CTL_TWO_RST;
            d.ctl_one = `CTL_ONE_RST;
            d.unlock = 1'b0;
            d.wdt = 16'h0000; // see [R09]
        end
    end

    // =====================================================
    // state register
    always_ff @(posedge mclk) begin
        if (srst) begin
            q <= '0;
            q.sys_rst <= 1'b1;
            q.ctl_two <= `CTL_TWO_RST;
            q.cfg_high <= `CFG_HIGH_RST;
            q.s1 <= 6'h01;
            q.s2 <= 6'h01;
            q.s3 <= 6'h01;
            q.filt <= 6'h01;
        end else begin
            q <= d;
        end
    end

    assign sys_rst = q.sys_rst;
    assign sfr_rdata = q.rdata;
    assign cfg_read_req = q.cfg_req;
    assign flash_write_unlock_flag = q.unlock;
    assign undervolt_detect_flag = q.detect;

    // =====================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence seq_cmd(logic [7:0] v);
        sfr.wr && !q.sys_rst && sfr.addr == `OFS_CMD_PORT && sfr.wdata == v;
    endsequence

    sequence seq_clr_wdt;
        sfr.wr && !q.sys_rst && sfr.addr == `OFS_CTL_ONE && sfr.wdata[`WDOG_CLR_BIT];
    endsequence

    AST_SW_RESET: assert property (seq_cmd(`CMD_SOFT_RESET) |=> sys_rst [*5]) // see [R05]
        else $error("software command did not hold reset");
    AST_UNLOCK: assert property (seq_cmd(`CMD_UNLOCK) |=> flash_write_unlock_flag) // see [R17]
        else $error("unlock command not taken");
    AST_CLR_PULSE: assert property (seq_clr_wdt |=> q.ctl_one[`WDOG_CLR_BIT]
                                    ##1 !q.ctl_one[`WDOG_CLR_BIT] && q.wdt == 16'h0000) // see [R10]
        else $error("watchdog clear bit not one cycle");
    AST_POR_HOLD: assert property (q.phase != PH_RUN |=> sys_rst) // see [R02]
        else $error("released before config load");
    AST_PIN_GATED: assert property (!q.cfg_high[`PINRST_EN_BIT] |-> !pin_req) // see [R04]
        else $error("pin reset while disabled");
    AST_PIN_TAKEN: assert property (pin_req |=> sys_rst ##1 sys_rst) // see [R03]
        else $error("pin reset not applied");
    AST_WDT_GATE: assert property (wdt_req |-> wdog_en[1] && (wdog_en[0] || normal_mode)) // see [R07]
        else $error("watchdog reset not permitted");
    AST_WDT_RANGE: assert property (src_rise && wdt_run |=> q.wdt < $past(wdt_limit)) // see [R08]
        else $error("watchdog count past period");
    AST_LVD_VALID: assert property (undervolt_detect_flag |-> $past(uv_sel) == 2'h3) // see [R12]
        else $error("detect flag outside 2.3 V setting");
    AST_STOP_SAVE: assert property (cpu_stop && q.ctl_two[`POWER_SAVE_BIT] |-> !undervolt_reset) // see [R13]
        else $error("undervolt reset in stop with power save");
    AST_DEFAULTS: assert property (sys_rst |=> q.option == `OPTION_RST
                                   && q.ctl_two == `CTL_TWO_RST && !q.unlock) // see [R14]
        else $error("register not at default after reset");
    AST_RELEASE: assert property ($fell(sys_rst) |-> q.phase == PH_RUN
                                  && $past(q.hold) == 3'h0) // see [R16]
        else $error("reset released with request pending");
endmodule

// ---- shared/rst_wdt_map.svh ----
`ifndef RST_WDT_MAP_SVH
`define RST_WDT_MAP_SVH
// =====================================================
// register offsets
`define OFS_OPTION      8'h94
`define OFS_FLAG_BANK   8'h95
`define OFS_CMD_PORT    8'h97
`define OFS_CTL_TWO     8'hF7
`define OFS_CTL_ONE     8'hF8
// =====================================================
// field positions
`define WDT_PSC_LSB     4
`define WDOG_EN_LSB     6
`define POWER_SAVE_BIT  5
`define WDOG_CLR_BIT    7
`define DETECT_BIT      7
`define PINRST_EN_BIT   6
`define UVSEL_LSB       4
// =====================================================
// command bytes and reset values
`define CMD_SOFT_RESET  8'h56
`define CMD_UNLOCK      8'h65
`define OPTION_RST      8'h00
`define CTL_ONE_RST     8'h00
`define CTL_TWO_RST     8'h0E
`define CFG_HIGH_RST    8'h00
// =====================================================
// timing
`define MCLK_HZ         10000000
`define RC_SLOW_HZ      68000
`define WARMUP_MS       40
`define WDT_BASE_MS     480
`define PIN_MIN_TICKS   2'h2
`define HOLD_CYCLES     3'h4
`endif

// ---- shared/rst_wdt_pkg.sv ----
package rst_wdt_pkg;
    typedef enum logic [1:0] {PH_WARMUP, PH_CFG_LOAD, PH_RUN} phase_type;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sfr_req_type;
    typedef struct packed {
        logic below_4v3;
        logic below_3v6;
        logic below_2v8;
        logic below_2v3;
    } uv_cmp_type;
    typedef struct packed {
        phase_type   phase;
        logic [18:0] warm;
        logic [7:0]  cfg_high;
        logic [5:0]  s1;
        logic [5:0]  s2;
        logic [5:0]  s3;
        logic [5:0]  filt;
        logic [1:0]  pin_cnt;
        logic [15:0] wdt;
        logic [2:0]  hold;
        logic        sys_rst;
        logic [7:0]  option;
        logic [7:0]  ctl_two;
        logic [7:0]  ctl_one;
        logic        unlock;
        logic        detect;
        logic [7:0]  rdata;
        logic        cfg_req;
    } state_type;
endpackage

// ---- tb/cfg_rom_model.sv ----
`timescale 1ns/1ns
// ==========
// config byte store that answers the block's fetch
module cfg_rom_model #(
    parameter int LAT = 3
) (
    // clock and stored byte
    input  wire logic       mclk,
    input  wire logic [7:0] cfg_value,
    // fetch handshake
    input  wire logic       cfg_read_req,
    output logic            cfg_read_ack,
    output logic [7:0]      cfg_read_data
);
    int cnt = 0;
    initial cfg_read_ack = 1'b0;
    initial cfg_read_data = 8'hA5;
    always @(posedge mclk) begin
        cfg_read_ack <= 1'b0;
        // data toggles outside the ack so stale bytes never look valid
        cfg_read_data <= ~cfg_read_data;
        if (cfg_read_req && !cfg_read_ack) begin
            cnt <= cnt + 1;
            if (cnt == LAT) begin
                cfg_read_ack <= 1'b1;
                cfg_read_data <= cfg_value;
                cnt <= 0;
            end
        end
    end
endmodule

// ---- tb/reset_and_watchdog_control_tb_top.sv ----
`timescale 1ns/1ns
module reset_and_watchdog_control_tb_top;
    import rst_wdt_pkg::*;
    // ==========
    // stimulus and results
    logic        mclk = 0;
    logic        srst = 1;
    logic        pin_n = 1;
    logic        slow_rc = 0;
    uv_cmp_type  uv = '0;
    logic        cpu_idle = 0;
    logic        cpu_stop = 0;
    sfr_req_type sfr = '0;
    logic [7:0]  rdata;
    logic [7:0]  cfg_value = 8'h00;
    logic [7:0]  cfg_data;
    logic [7:0]  v;
    logic        cfg_req;
    logic        cfg_ack;
    logic        sys_rst;
    logic        unlock;
    logic        detect;
    int          err_total = 0;
    int          n_tests = 0;
    int          ticks = 0;
    initial forever #50 mclk = ~mclk;
    // slow rc period is four mclk periods
    initial forever #200 slow_rc = ~slow_rc;
    reset_and_watchdog_control #(.WARMUP_CYCLES(20)) i_dut (
        .mclk(mclk), .srst(srst), .ext_reset_n(pin_n), .slow_internal_rc(slow_rc),
        .uv_cmp(uv), .cpu_idle(cpu_idle), .cpu_stop(cpu_stop), .sfr(sfr),
        .sfr_rdata(rdata), .cfg_read_req(cfg_req), .cfg_read_ack(cfg_ack),
        .cfg_read_data(cfg_data), .sys_rst(sys_rst), .flash_write_unlock_flag(unlock),
        .undervolt_detect_flag(detect));
    cfg_rom_model i_rom (
        .mclk(mclk), .cfg_value(cfg_value), .cfg_read_req(cfg_req),
        .cfg_read_ack(cfg_ack), .cfg_read_data(cfg_data));
    // ==========
    // shared tasks
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // an idle edge after each strobe keeps back-to-back calls from driving sfr twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr = '{a, d, 1'b1, 1'b0};
        cyc(1);
        sfr = '0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr = '{a, 8'h00, 1'b0, 1'b1};
        cyc(1);
        sfr = '0;
        d = rdata;
        cyc(1);
    endtask
    task automatic wait_rst(input logic lvl, input int lim);
        for (int i = 0; i < lim && sys_rst !== lvl; i++) cyc(1);
        chk({7'h0, sys_rst}, {7'h0, lvl});
    endtask
    task automatic quiet(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            cyc(1);
            if (sys_rst !== 1'b0) hits++;
        end
        chk(8'(hits), 8'h00);
    endtask
    task automatic power_up(input logic [7:0] cfg);
        cfg_value = cfg;
        srst = 1;
        cyc(12);
        srst = 0;
        cyc(18);
        chk({7'h0, sys_rst}, 8'h01);
        chk({7'h0, cfg_req}, 8'h00);
        cyc(3);
        chk({7'h0, cfg_req}, 8'h01);
        chk({7'h0, sys_rst}, 8'h01);
        wait_rst(0, 40);
    endtask
    // ==========
    // scenarios
    task automatic sc_defaults_swreset();
        rd(8'h94, v);
        chk(v, 8'h00);
        rd(8'hF7, v);
        chk(v, 8'h0E);
        wr(8'hF7, 8'h20);
        wr(8'h94, 8'h30);
        wr(8'h97, 8'h56);
        wait_rst(1, 4);
        // unlock written while reset stands must be dropped
        wr(8'h97, 8'h65);
        wait_rst(0, 20);
        chk({7'h0, unlock}, 8'h00);
        rd(8'hF7, v);
        chk(v, 8'h0E);
        rd(8'h94, v);
        chk(v, 8'h00);
    endtask
    task automatic sc_unlock();
        wr(8'h97, 8'h65);
        rd(8'h97, v);
        chk(v, 8'h01);
        chk({7'h0, unlock}, 8'h01);
        wr(8'h97, 8'h00);
        rd(8'h97, v);
        chk(v, 8'h00);
        wr(8'hF8, 8'h80);
        cyc(1);
        rd(8'hF8, v);
        chk(v, 8'h00);
    endtask
    task automatic sc_pin_off_uv_sel00();
        pin_n = 0;
        quiet(40);
        pin_n = 1;
        uv.below_2v8 = 1;
        quiet(12);
        chk({7'h0, detect}, 8'h00);
        uv.below_3v6 = 1;
        wait_rst(1, 12);
        uv = '0;
        wait_rst(0, 20);
        // idle with power save drops to the 2.3 V level
        wr(8'hF7, 8'h20);
        cpu_idle = 1;
        uv.below_3v6 = 1;
        quiet(12);
        uv.below_2v3 = 1;
        wait_rst(1, 12);
        uv = '0;
        cpu_idle = 0;
        wait_rst(0, 20);
    endtask
    task automatic sc_uv_level(input logic [7:0] cfg, input uv_cmp_type safe,
                               input uv_cmp_type low);
        power_up(cfg);
        uv = safe;
        quiet(12);
        uv = low;
        wait_rst(1, 12);
        uv = '0;
        wait_rst(0, 20);
    endtask
    task automatic sc_pin_on();
        // under two slow edges must be filtered out
        pin_n = 0;
        cyc(3);
        pin_n = 1;
        quiet(30);
        pin_n = 0;
        wait_rst(1, 30);
        pin_n = 1;
        wait_rst(0, 30);
    endtask
    task automatic sc_uv_sel11();
        uv.below_2v8 = 1;
        cyc(10);
        chk({7'h0, detect}, 8'h01);
        rd(8'h95, v);
        chk(v, 8'h80);
        cpu_stop = 1;
        cyc(4);
        chk({7'h0, detect}, 8'h00);
        uv.below_2v3 = 1;
        quiet(20);
        cpu_stop = 0;
        wait_rst(1, 12);
        uv = '0;
        wait_rst(0, 20);
    endtask
    task automatic sc_watchdog();
        wr(8'h94, 8'h30);
        wr(8'hF8, 8'h80);
        wr(8'hF7, 8'h80);
        cyc(8000);
        wr(8'hF8, 8'h80);
        quiet(12000);
        wait_rst(1, 5000);
        wait_rst(0, 30);
    endtask
    // ==========
    // main sequence and hang guard
    always @(posedge mclk) begin
        ticks++;
        if (ticks == 80000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        power_up(8'h00);
        sc_defaults_swreset();
        sc_unlock();
        sc_pin_off_uv_sel00();
        sc_uv_level(8'h10, 4'hC, 4'hE);
        sc_uv_level(8'h20, 4'h0, 4'h8);
        power_up(8'h70);
        sc_pin_on();
        sc_uv_sel11();
        sc_watchdog();
        wrap_up();
    end
endmodule
